// ===== sar_adc_regs.vh
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH
`define ADDR_CONTROL_0      4'h0
`define ADDR_CONTROL_1      4'h1
`define ADDR_RESULT_HIGH    4'h2
`define ADDR_RESULT_LOW     4'h3
`define ADDR_FLAGS          4'h4
`define ADDR_ENABLES        4'h5
`define ADDR_INT_CONTROL    4'h6
`define CTL0_ENABLE_BIT     0
`define CTL0_GO_BIT         1
`define CTL0_CHAN_LSB       2
`define CTL1_PREF_LSB       0
`define CTL1_CLK_LSB        4
`define CTL1_FMT_BIT        7
`define FLAG_DONE_BIT       0
`define INTC_GLOBAL_BIT     7
`define INTC_PERIPH_BIT     6
`define RESET_BYTE          8'h00
`define RESET_RESULT        10'h000
`define CLK_DIV2            3'h0
`define CLK_DIV4            3'h4
`define CLK_DIV8            3'h1
`define CLK_DIV16           3'h5
`define CLK_DIV32           3'h2
`define CLK_DIV64           3'h6
`define HALF_DIV2           7'h01
`define HALF_DIV4           7'h02
`define HALF_DIV8           7'h04
`define HALF_DIV16          7'h08
`define HALF_DIV32          7'h10
`define HALF_DIV64          7'h20
`define SETTLE_HALVES       5'h03
`endif

// ===== sar_adc_sequencer.v
// successive-approximation converter sequencer with its control and result registers
//
// Notes on behaviour
// - converts selected input into a 10-bit value held in the result pair.
// - up to 17 sources: analog pins, temperature, DAC output, reference buffer.
// - channel_select field drives the mux feeding the sample-and-hold.
// - positive_ref_select picks pin, supply, 2.048V or 4.096V.
// - clock codes 000/100/001/101/010/110 divide by 2..64; x11 picks internal RC.
// - one bit per bit_period; a full conversion takes 11.5 bit periods.
// - divided clocks follow the system clock; the internal RC does not.
// - converter runs in sleep only with the internal RC clock selected.
// - done flag sets at the end of every conversion, enabled or not.
// - hardware never clears the done flag; software writes it clear.
// - interrupt request only while irq enable and done flag are both set.
// - interrupt during sleep wakes the device to the next instruction.
// - wake needs irq and peripheral enables; global enable selects branch.
// - result_format selects left or right justification of the result pair.
// - right: six upper high bits zero; left: six lower low bits zero.
// - setting the go bit starts a conversion; hardware clears it at the end.
// - on completion the new result is written to the high and low registers.
//
// Local design decisions: the register addresses and strobed register access.
`include "sar_adc_regs.vh"

module sar_adc_sequencer #(
	parameter RES_BITS = 10
) (
	// clock and reset
	input  wire                clk,
	input  wire                sys_rst,
	// register port
	input  wire [3:0]          reg_addr,
	input  wire [7:0]          reg_wdata,
	input  wire                reg_wr,
	input  wire                reg_rd,
	output reg  [7:0]          reg_rdata_ff,
	// internal RC oscillator tick and power state
	input  wire                rc_tick,
	input  wire                sleep_mode,
	// analog front end
	input  wire                comp_out,
	output reg  [4:0]          channel_select_ff,
	output reg  [1:0]          positive_ref_select_ff,
	output reg  [RES_BITS-1:0] dac_trial_ff,
	output reg                 sample_hold_ff,
	output reg                 converter_on_ff,
	// interrupt and wake
	output reg                 irq_request_ff,
	output reg                 wake_ff,
	output reg                 wake_to_isr_ff
);

	localparam ST_IDLE   = 3'b001;
	localparam ST_SETTLE = 3'b010;
	localparam ST_CONV   = 3'b100;
	// index of the msb trial, cut to the width of the bit counter
	localparam integer TOP_IDX = RES_BITS - 1;

	reg  [7:0]          ctl0_ff;
	reg  [7:0]          ctl1_ff;
	reg                 done_flag_ff;
	reg                 irq_en_ff;
	reg  [1:0]          intc_ff;
	reg  [RES_BITS-1:0] result_ff;
	reg  [2:0]          state_ff;
	reg  [6:0]          div_cnt_ff;
	reg  [4:0]          half_cnt_ff;
	reg  [3:0]          bit_idx_ff;
	reg                 comp_meta_ff;
	reg                 comp_sync_ff;
	reg                 rc_meta_ff;
	reg                 rc_sync_ff;
	reg                 rc_prev_ff;
	reg                 sleep_meta_ff;
	reg                 sleep_sync_ff;

	wire [2:0] clk_sel  = ctl1_ff[`CTL1_CLK_LSB+2:`CTL1_CLK_LSB];
	wire       use_rc   = clk_sel[0] & clk_sel[1];
	wire       fmt_right = ctl1_ff[`CTL1_FMT_BIT];
	wire       go_bit   = ctl0_ff[`CTL0_GO_BIT];
	wire       adc_on   = ctl0_ff[`CTL0_ENABLE_BIT];

	// comparator loop: trial flop plus two sync stages costs three clocks, so a
	// divide-by-2 bit_period decides on the previous comparison; software must treat
	// it like the other too-fast settings

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			comp_meta_ff  <= 1'b0;
			comp_sync_ff  <= 1'b0;
			rc_meta_ff    <= 1'b0;
			rc_sync_ff    <= 1'b0;
			rc_prev_ff    <= 1'b0;
			sleep_meta_ff <= 1'b0;
			sleep_sync_ff <= 1'b0;
		end else begin
			comp_meta_ff  <= comp_out;
			comp_sync_ff  <= comp_meta_ff;
			rc_meta_ff    <= rc_tick;
			rc_sync_ff    <= rc_meta_ff;
			rc_prev_ff    <= rc_sync_ff;
			sleep_meta_ff <= sleep_mode;
			sleep_sync_ff <= sleep_meta_ff;
		end
	end

	// ------------------------------------------------------------
	// half bit_period tick: each edge of the conversion clock
	// ------------------------------------------------------------
	reg  [6:0] half_div;
	always @* begin
		case (clk_sel)
			`CLK_DIV2:  half_div = `HALF_DIV2;
			`CLK_DIV4:  half_div = `HALF_DIV4;
			`CLK_DIV8:  half_div = `HALF_DIV8;
			`CLK_DIV16: half_div = `HALF_DIV16;
			`CLK_DIV32: half_div = `HALF_DIV32;
			`CLK_DIV64: half_div = `HALF_DIV64;
			default:    half_div = `HALF_DIV2;
		endcase
	end

	// divided clocks count system edges, so a slower system clock stretches bit_period
	wire div_half = (div_cnt_ff + 7'h01 >= half_div);
	wire rc_half  = rc_sync_ff ^ rc_prev_ff;
	wire half_tick = use_rc ? rc_half : div_half;
	// a divided clock stops in sleep, aborting the conversion; the RC keeps going
	wire sleep_abort = sleep_sync_ff & ~use_rc;

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	wire sw_go_clear = reg_wr & (reg_addr == `ADDR_CONTROL_0) & ~reg_wdata[`CTL0_GO_BIT];
	wire conv_last   = (state_ff == ST_CONV) & half_tick & half_cnt_ff[0] &
	                   (bit_idx_ff == 4'h0);
	wire conv_end    = conv_last | ((state_ff != ST_IDLE) & (sw_go_clear | sleep_abort | ~adc_on));

	// partial result on early stop: undecided bits copy the last decided bit
	// an abort while settling keeps the previous result untouched; one during the msb trial stores zero
	reg  [RES_BITS-1:0] final_code;
	integer k;
	always @* begin
		final_code = dac_trial_ff;
		if (conv_last)
			final_code[0] = comp_sync_ff;
		else if (state_ff == ST_CONV) begin
			for (k = 0; k < RES_BITS; k = k + 1)
				if (k <= bit_idx_ff)
					final_code[k] = (bit_idx_ff == RES_BITS - 1) ? 1'b0 :
					                dac_trial_ff[bit_idx_ff + 1];
		end else
			final_code = result_ff;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			state_ff       <= ST_IDLE;
			div_cnt_ff     <= 7'h00;
			half_cnt_ff    <= 5'h00;
			bit_idx_ff     <= 4'h0;
			dac_trial_ff   <= `RESET_RESULT;
			sample_hold_ff <= 1'b0;
		end else begin
			div_cnt_ff <= (div_half | state_ff[0]) ? 7'h00 : div_cnt_ff + 7'h01;
			case (state_ff)
				ST_IDLE: begin
					sample_hold_ff <= adc_on;
					half_cnt_ff    <= 5'h00;
					if (go_bit & adc_on & ~sleep_abort) begin
						state_ff <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					// 1.5 bit_period: hold the sample, then begin the msb trial
					if (conv_end) begin
						state_ff <= ST_IDLE;
					end else if (half_tick) begin
						if (half_cnt_ff + 5'h01 == `SETTLE_HALVES) begin
							sample_hold_ff <= 1'b0;
							half_cnt_ff    <= 5'h00;
							bit_idx_ff     <= TOP_IDX[3:0];
							dac_trial_ff   <= {1'b1, {(RES_BITS-1){1'b0}}};
							state_ff       <= ST_CONV;
						end else
							half_cnt_ff <= half_cnt_ff + 5'h01;
					end
				end
				ST_CONV: begin
					// one decision per full bit_period, msb first: 1.5 + 10 = 11.5
					if (conv_end) begin
						state_ff <= ST_IDLE;
					end else if (half_tick) begin
						half_cnt_ff[0] <= ~half_cnt_ff[0];
						if (half_cnt_ff[0]) begin
							dac_trial_ff[bit_idx_ff] <= comp_sync_ff;
							if (bit_idx_ff != 4'h0)
								dac_trial_ff[bit_idx_ff - 1] <= 1'b1;
							bit_idx_ff <= bit_idx_ff - 4'h1;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// one decode per writable register; unmapped indices match none and are dropped
	wire wr_c0    = reg_wr & (reg_addr == `ADDR_CONTROL_0);
	wire wr_c1    = reg_wr & (reg_addr == `ADDR_CONTROL_1);
	wire wr_flags = reg_wr & (reg_addr == `ADDR_FLAGS);
	wire wr_en    = reg_wr & (reg_addr == `ADDR_ENABLES);
	wire wr_intc  = reg_wr & (reg_addr == `ADDR_INT_CONTROL);
	always @(posedge clk) begin
		if (sys_rst) begin
			ctl0_ff      <= `RESET_BYTE;
			ctl1_ff      <= `RESET_BYTE;
			done_flag_ff <= 1'b0;
			irq_en_ff    <= 1'b0;
			intc_ff      <= 2'b00;
			result_ff    <= `RESET_RESULT;
		end else begin
			if (wr_c0)
				ctl0_ff <= {1'b0, reg_wdata[6:0]};
			if (wr_c1)
				ctl1_ff <= reg_wdata & 8'hF3;
			if (wr_en)
				irq_en_ff <= reg_wdata[`FLAG_DONE_BIT];
			if (wr_intc)
				intc_ff <= {reg_wdata[`INTC_GLOBAL_BIT], reg_wdata[`INTC_PERIPH_BIT]};
			if (conv_end) begin
				ctl0_ff[`CTL0_GO_BIT] <= 1'b0;
				result_ff <= final_code;
			end
			// set beats a same-cycle software clear; hardware never clears it
			if (conv_last)
				done_flag_ff <= 1'b1;
			else if (wr_flags)
				done_flag_ff <= reg_wdata[`FLAG_DONE_BIT];
		end
	end

	// justification applied on read so format is a view of the stored code
	wire [15:0] just = fmt_right ? {6'h00, result_ff} : {result_ff, 6'h00};

	reg  [7:0] rd_mux;
	always @* begin
		case (reg_addr)
			`ADDR_CONTROL_0:   rd_mux = ctl0_ff;
			`ADDR_CONTROL_1:   rd_mux = ctl1_ff;
			`ADDR_RESULT_HIGH: rd_mux = just[15:8];
			`ADDR_RESULT_LOW:  rd_mux = just[7:0];
			`ADDR_FLAGS:       rd_mux = {7'h00, done_flag_ff};
			`ADDR_ENABLES:     rd_mux = {7'h00, irq_en_ff};
			`ADDR_INT_CONTROL: rd_mux = {intc_ff, 6'h00};
			default:           rd_mux = `RESET_BYTE;
		endcase
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata_ff           <= `RESET_BYTE;
			channel_select_ff      <= 5'h00;
			positive_ref_select_ff <= 2'b00;
			converter_on_ff        <= 1'b0;
		end else begin
			reg_rdata_ff           <= reg_rd ? rd_mux : `RESET_BYTE;
			channel_select_ff      <= ctl0_ff[`CTL0_CHAN_LSB+4:`CTL0_CHAN_LSB];
			positive_ref_select_ff <= ctl1_ff[`CTL1_PREF_LSB+1:`CTL1_PREF_LSB];
			// a divided clock in sleep powers the converter down; the enable bit keeps its value
			converter_on_ff        <= adc_on & ~sleep_abort;
		end
	end

	// ------------------------------------------------------------
	// interrupt request and wake
	// ------------------------------------------------------------
	// levels that follow the flag and enables one cycle late, so clearing the
	// flag drops the request with no separate acknowledge
	wire irq_now  = irq_en_ff & done_flag_ff;
	wire wake_arm = irq_now & intc_ff[0] & sleep_sync_ff;
	always @(posedge clk) begin
		if (sys_rst) begin
			irq_request_ff <= 1'b0;
			wake_ff        <= 1'b0;
			wake_to_isr_ff <= 1'b0;
		end else begin
			irq_request_ff <= irq_now;
			wake_ff        <= wake_arm;
			// global enable only picks the branch; the wake itself does not need it
			wake_to_isr_ff <= wake_arm & intc_ff[1];
		end
	end

endmodule // sar_adc_sequencer

// ===== sar_adc_sequencer_props.sv
// port property checker for the converter sequencer
`include "sar_adc_regs.vh"
// ----------------------------------------
// checker
// ----------------------------------------
module sar_adc_sequencer_props #(parameter RES_BITS = 10) (
	// clock and reset
	input wire       clk,
	input wire       sys_rst,
	// register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata_ff,
	// front end, power and interrupt
	input wire       sleep_mode,
	input wire [4:0] channel_select_ff,
	input wire [1:0] positive_ref_select_ff,
	input wire       irq_request_ff,
	input wire       wake_ff,
	input wire       wake_to_isr_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata_ff == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	// register then output flop: a written field shows two cycles later
	property p_chan_wr;
		reg_wr && reg_addr == `ADDR_CONTROL_0 |-> ##2 channel_select_ff == $past(reg_wdata[6:2], 2);
	endproperty
	a_chan_wr: assert property (p_chan_wr) else $error("channel not taken");
	property p_chan_hold;
		!$past(reg_wr && reg_addr == `ADDR_CONTROL_0) |=> $stable(channel_select_ff);
	endproperty
	a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
	property p_ref_wr;
		reg_wr && reg_addr == `ADDR_CONTROL_1 |-> ##2
			positive_ref_select_ff == $past(reg_wdata[1:0], 2);
	endproperty
	a_ref_wr: assert property (p_ref_wr) else $error("reference not taken");
	// the flag only goes away by a software write, so neither may irq
	property p_irq_hold; $fell(irq_request_ff) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
	property p_wake_irq; $rose(wake_ff) |-> irq_request_ff || $past(irq_request_ff); endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake without irq");
	// two sync stages and the wake flop: the pin level three cycles back
	property p_wake_sleep; $rose(wake_ff) |-> $past(sleep_mode, 3); endproperty
	a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
	property p_isr; wake_to_isr_ff |-> wake_ff || $past(wake_ff); endproperty
	a_isr: assert property (p_isr) else $error("isr branch without wake");
	c_irq: cover property ($rose(irq_request_ff));
	c_wake: cover property ($rose(wake_ff));
	c_isr: cover property ($rose(wake_to_isr_ff));
endmodule // sar_adc_sequencer_props

bind sar_adc_sequencer sar_adc_sequencer_props #(.RES_BITS(RES_BITS)) props_i (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .sleep_mode(sleep_mode),
	.channel_select_ff(channel_select_ff), .positive_ref_select_ff(positive_ref_select_ff),
	.irq_request_ff(irq_request_ff), .wake_ff(wake_ff), .wake_to_isr_ff(wake_to_isr_ff));

// ===== analog_front_model.sv
// comparator model of the input held in the sample-and-hold
// ----------------------------------------
// front end
// ----------------------------------------
module analog_front_model (
	// converter side
	input  wire logic [9:0] dac_trial_ff,
	input  wire logic       sample_hold_ff,
	input  wire logic [9:0] level,
	output logic            comp_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] held;
	// captured only while tracking, so a late level change cannot leak into a conversion
	always @* if (sample_hold_ff) held = level;
	assign comp_out = (held >= dac_trial_ff);
endmodule // analog_front_model

// ===== test_sar_adc_sequencer.sv
// self-checking bench for the converter sequencer
`include "sar_adc_regs.vh"
// ----------------------------------------
// bench
// ----------------------------------------
module test_sar_adc_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       sleep_mode = 1'b0;
	logic [9:0] level = 10'h000;
	logic [1:0] rc_cnt = 2'h0;
	wire  [7:0] rdata;
	wire  [4:0] chan;
	wire  [9:0] trial;
	wire        sh, comp, irq, wake, isr, con;
	int         err_count = 0;
	int         checks = 0;
	always #5 clk = ~clk;
	always @(posedge clk) rc_cnt <= rc_cnt + 2'h1;
	sar_adc_sequencer sar_adc_sequencer_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
		.rc_tick(rc_cnt[1]), .sleep_mode(sleep_mode), .comp_out(comp), .channel_select_ff(chan),
		.positive_ref_select_ff(), .dac_trial_ff(trial), .sample_hold_ff(sh),
		.converter_on_ff(con), .irq_request_ff(irq), .wake_ff(wake), .wake_to_isr_ff(isr));
	analog_front_model analog_front_model_i (.dac_trial_ff(trial), .sample_hold_ff(sh),
		.level(level), .comp_out(comp));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic reg_map;
		logic [7:0] d;
		for (int a = 0; a < 16; a++) begin
			rd(4'(a), d);
			chk(d, 8'h00);
		end
		wr(4'hF, 8'hFF);
		rd(4'hF, d);
		chk(d, 8'h00);
		wr(`ADDR_CONTROL_1, 8'hFF);
		rd(`ADDR_CONTROL_1, d);
		chk(d, 8'hF3);
		wr(`ADDR_CONTROL_0, 8'hFC);
		rd(`ADDR_CONTROL_0, d);
		chk(d, 8'h7C);
		chk({3'h0, chan}, 8'h1F);
		wr(`ADDR_CONTROL_0, 8'h00);
	endtask
	// one conversion on channel 5; half is the bit period in clock cycles over two
	task automatic convert(input logic [7:0] ctl1, input logic [9:0] v, input int half);
		logic [7:0] d;
		logic [7:0] hi;
		logic [7:0] lo;
		time t0;
		int n;
		@(posedge clk);
		// the selected pin stands set up as an analog input before any conversion
		level <= v;
		wr(`ADDR_CONTROL_1, ctl1);
		wr(`ADDR_FLAGS, 8'h00);
		wr(`ADDR_CONTROL_0, 8'h15);
		repeat (4) @(posedge clk);
		wr(`ADDR_CONTROL_0, 8'h17);
		t0 = $time;
		n = 0;
		d = 8'h02;
		while (d[1] && n < 400) begin
			rd(`ADDR_CONTROL_0, d);
			n++;
		end
		chk(d, 8'h15);
		n = int'(($time - t0) / 10);
		chk({7'h00, n >= 23 * half - 2 && n <= 23 * half + 12}, 8'h01);
		rd(`ADDR_FLAGS, d);
		chk(d, 8'h01);
		hi = ctl1[7] ? {6'h00, v[9:8]} : v[9:2];
		lo = ctl1[7] ? v[7:0] : {v[1:0], 6'h00};
		rd(`ADDR_RESULT_HIGH, d);
		chk(d, hi);
		rd(`ADDR_RESULT_LOW, d);
		chk(d, lo);
	endtask
	task automatic dividers;
		logic [2:0] code [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
		logic [9:0] val [6] = '{10'h3FF, 10'h000, 10'h2AA, 10'h155, 10'h201, 10'h1FE};
		for (int i = 0; i < 6; i++) begin
			convert({i[0], code[i], 2'h0, 2'(i)}, val[i], 1 << i);
		end
	endtask
	task automatic sleep_wake;
		wr(`ADDR_ENABLES, 8'h01);
		wr(`ADDR_INT_CONTROL, 8'h40);
		@(posedge clk);
		sleep_mode <= 1'b1;
		convert(8'hB0, 10'h0F0, 2);
		chk({7'h00, con}, 8'h01);
		repeat (4) @(posedge clk);
		chk({5'h00, irq, wake, isr}, 8'h06);
		wr(`ADDR_INT_CONTROL, 8'hC0);
		repeat (3) @(posedge clk);
		chk({5'h00, irq, wake, isr}, 8'h07);
		wr(`ADDR_FLAGS, 8'h00);
		repeat (3) @(posedge clk);
		chk({5'h00, irq, wake, isr}, 8'h00);
		sleep_mode <= 1'b0;
		wr(`ADDR_ENABLES, 8'h00);
		wr(`ADDR_INT_CONTROL, 8'h00);
		convert(8'h70, 10'h3C3, 2);
	endtask
	task automatic sleep_abort;
		logic [7:0] d;
		wr(`ADDR_FLAGS, 8'h00);
		wr(`ADDR_CONTROL_1, 8'hE0);
		wr(`ADDR_CONTROL_0, 8'h17);
		repeat (40) @(posedge clk);
		sleep_mode <= 1'b1;
		repeat (800) @(posedge clk);
		rd(`ADDR_FLAGS, d);
		chk(d, 8'h00);
		chk({7'h00, con}, 8'h00);
		rd(`ADDR_CONTROL_0, d);
		chk(d, 8'h15);
		@(posedge clk);
		sleep_mode <= 1'b0;
		wr(`ADDR_CONTROL_0, 8'h00);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		reg_map();
		dividers();
		sleep_wake();
		sleep_abort();
		report_and_stop();
	end
endmodule // test_sar_adc_sequencer
